// ===== rtl/cal_pkg.sv
// Package for the add/logic/shift execution datapath subset.
// Assumes an 8-bit CPU core with a byte-wide system bus.
package cal_pkg;
  localparam int  CAL_DATA_W     = 8;
  localparam int  CAL_ADDR_W     = 16;
  // Flag positions in the condition flags register
  localparam int  CAL_FLAG_V     = 7;
  localparam int  CAL_FLAG_H     = 4;
  localparam int  CAL_FLAG_I     = 3;
  localparam int  CAL_FLAG_N     = 2;
  localparam int  CAL_FLAG_Z     = 1;
  localparam int  CAL_FLAG_C     = 0;
  // Reset values
  localparam logic [7:0]  CAL_FLAGS_RST = 8'h68;
  localparam logic [7:0]  CAL_BYTE_RST  = 8'h00;
  localparam logic [15:0] CAL_SP_RST    = 16'h00FF;
  localparam logic [15:0] CAL_WORD_RST  = 16'h0000;
  // Opcodes
  localparam logic [7:0]  CAL_OP_PREFIX = 8'h9E;
  localparam logic [7:0]  CAL_OP_ADC_IMM = 8'hA9;
  localparam logic [7:0]  CAL_OP_ADD_IMM = 8'hAB;
  localparam logic [7:0]  CAL_OP_AND_IMM = 8'hA4;
  localparam logic [7:0]  CAL_OP_SP_ADJ  = 8'hA7;
  localparam logic [7:0]  CAL_OP_IX_ADJ  = 8'hAF;
  localparam logic [7:0]  CAL_OP_ASL_DIR = 8'h38;
  localparam logic [7:0]  CAL_OP_ASL_A   = 8'h48;
  localparam logic [7:0]  CAL_OP_ASL_X   = 8'h58;
  localparam logic [7:0]  CAL_OP_ASL_IX1 = 8'h68;
  localparam logic [7:0]  CAL_OP_ASL_IX  = 8'h78;
  localparam logic [7:0]  CAL_OP_ASR_DIR = 8'h37;
  localparam logic [7:0]  CAL_OP_ASR_A   = 8'h47;
  localparam logic [7:0]  CAL_OP_ASR_X   = 8'h57;
  localparam logic [7:0]  CAL_OP_ASR_IX1 = 8'h67;
  localparam logic [7:0]  CAL_OP_ASR_IX  = 8'h77;
  // Low nibbles of the arithmetic group opcodes, then high nibbles of the stack forms
  localparam logic [3:0]  CAL_LO_ADC = 4'h9;
  localparam logic [3:0]  CAL_LO_ADD = 4'hB;
  localparam logic [3:0]  CAL_LO_AND = 4'h4;
  localparam logic [3:0]  CAL_HI_SP2 = 4'hD;
  localparam logic [3:0]  CAL_HI_SP1 = 4'hE;

  typedef enum logic [2:0]
  {
    CAL_ALU_NONE,
    CAL_ALU_ADC,
    CAL_ALU_ADD,
    CAL_ALU_AND,
    CAL_ALU_ASL,
    CAL_ALU_ASR
  } cal_alu_e;

  // Bus cycle codes
  typedef enum logic [1:0]
  {
    CAL_CYC_P,
    CAL_CYC_R,
    CAL_CYC_W,
    CAL_CYC_F
  } cal_cyc_e;
endpackage

// ===== rtl/cal_alu_if.sv
// Carrier between the sequencer and the arithmetic unit.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface cal_alu_if;
  import cal_pkg::*;
  cal_alu_e    op;
  logic [7:0]  a;
  logic [7:0]  m;
  logic [7:0]  flags_in;
  logic [7:0]  result;
  logic [7:0]  flags_out;
  modport seq (output op, output a, output m, output flags_in, input result, input flags_out);
  modport alu (input op, input a, input m, input flags_in, output result, output flags_out);
endinterface

// ===== rtl/cal_alu.sv
// Combinational add, AND and shift unit with flag generation.
// Assumes the caller holds operands stable for the cycle.
`timescale 1ns/1ps
module cal_alu
  import cal_pkg::*;
(
  cal_alu_if.alu  alu
);
  import cal_pkg::*;

  logic [8:0] sum;
  logic [7:0] r;
  logic [7:0] f;
  logic       cin;

  always_comb
  begin
    f   = alu.flags_in;
    r   = alu.a;
    cin = (alu.op == CAL_ALU_ADC) ? alu.flags_in[CAL_FLAG_C] : 1'b0;
    sum = {1'b0, alu.a} + {1'b0, alu.m} + {8'h00, cin};
    unique case (alu.op)
      CAL_ALU_ADC, CAL_ALU_ADD:
      begin
        r = sum[7:0];
        f[CAL_FLAG_V] = (alu.a[7] & alu.m[7] & ~r[7]) | (~alu.a[7] & ~alu.m[7] & r[7]);
        f[CAL_FLAG_H] = (alu.a[3] & alu.m[3]) | (alu.m[3] & ~r[3]) | (~r[3] & alu.a[3]);
        f[CAL_FLAG_C] = sum[8];
      end
      CAL_ALU_AND:
      begin
        r = alu.a & alu.m;
        f[CAL_FLAG_V] = 1'b0;
      end
      CAL_ALU_ASL:
      begin
        r = {alu.m[6:0], 1'b0};
        f[CAL_FLAG_C] = alu.m[7];
        f[CAL_FLAG_V] = r[7] ^ alu.m[7];
      end
      CAL_ALU_ASR:
      begin
        r = {alu.m[7], alu.m[7:1]};
        f[CAL_FLAG_C] = alu.m[0];
        f[CAL_FLAG_V] = r[7] ^ alu.m[0];
      end
      default:
      begin
        r = alu.a;
      end
    endcase
    if (alu.op != CAL_ALU_NONE)
    begin
      f[CAL_FLAG_N] = r[7];
      f[CAL_FLAG_Z] = (r == 8'h00);
    end
    alu.result    = r;
    alu.flags_out = f;
  end
endmodule

// ===== rtl/cal_core.sv
// Execution sequencer for add, AND, shift and pointer adjust.
// Assumes a byte bus answering reads in the same cycle.
`timescale 1ns/1ps

// Notes on behaviour
// - Adc adds accumulator, operand and carry
// - Add puts operand plus accumulator
// - Adds set overflow on signed overflow
// - Adds set half carry from bit 3
// - N is bit 7, Z if zero
// - Adds set carry from bit 7
// - Stack adjust adds sign-extended immediate
// - Index adjust adds sign-extended immediate
// - Adjust instructions leave flags untouched
// - And result, overflow cleared, H/C kept
// - Shift left, zero in, carry from b7
// - Shift left overflow is R7 xor b7
// - Shift right keeps sign, carry b0
// - Shift right overflow is R7 xor b0
// - Bus cycles coded p, r, w, f
module cal_core
  import cal_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  output logic [CAL_ADDR_W-1:0]       bus_addr,
  output logic [CAL_DATA_W-1:0]       bus_wdata,
  input  wire logic [CAL_DATA_W-1:0]  bus_rdata,
  output logic                        bus_rd,
  output logic                        bus_wr,
  output cal_pkg::cal_cyc_e           bus_cycle,
  output logic [CAL_DATA_W-1:0]       accum,
  output logic [CAL_DATA_W-1:0]       xreg,
  output logic [CAL_DATA_W-1:0]       hreg,
  output logic [CAL_ADDR_W-1:0]       stack_ptr,
  output logic [CAL_ADDR_W-1:0]       prog_ctr,
  output logic [CAL_DATA_W-1:0]       condition_flags_reg,
  output logic                        illegal_op
);
  import cal_pkg::*;

  typedef enum
  {
    CAL_FETCH,
    CAL_PREFIX,
    CAL_OPND,
    CAL_OFS2,
    CAL_READ,
    CAL_FREE,
    CAL_WRITE
  } cal_state_e;

  cal_state_e    state;
  logic [7:0]    opcode;
  logic          pfx;
  logic [15:0]   ea;
  logic [7:0]    operand;
  logic [7:0]    rmw_res;
  logic [15:0]   hx;
  cal_alu_if     aif ();

  cal_alu u_alu
  (
    .alu (aif)
  );

  function automatic logic [15:0] cal_sext(input logic [7:0] v);
    return {{8{v[7]}}, v};
  endfunction

  function automatic cal_alu_e cal_decode(input logic [7:0] op);
    cal_alu_e k;
    k = CAL_ALU_NONE;
    if (op[7:4] >= 4'hA)
    begin
      unique case (op[3:0])
        CAL_LO_ADC: k = CAL_ALU_ADC;
        CAL_LO_ADD: k = CAL_ALU_ADD;
        CAL_LO_AND: k = CAL_ALU_AND;
        default:    k = CAL_ALU_NONE;
      endcase
    end
    else if (op[7:4] >= 4'h3 && op[7:4] <= 4'h7)
    begin
      if (op[3:0] == 4'h8)
        k = CAL_ALU_ASL;
      else if (op[3:0] == 4'h7)
        k = CAL_ALU_ASR;
    end
    return k;
  endfunction

  assign hx = {hreg, xreg};

  logic       inh;
  logic       adj;
  cal_alu_e   kind;
  assign kind = cal_decode(opcode);
  assign inh  = (opcode[7:4] == 4'h4) || (opcode[7:4] == 4'h5);
  assign adj  = (opcode == CAL_OP_SP_ADJ) || (opcode == CAL_OP_IX_ADJ);

  // Bus strobes per state
  // cycle code per state
  always_comb
  begin
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_addr  = prog_ctr;
    bus_wdata = rmw_res;
    bus_cycle = CAL_CYC_P;
    unique case (state)
      CAL_FETCH, CAL_PREFIX, CAL_OPND, CAL_OFS2:
      begin
        bus_rd = 1'b1;
      end
      CAL_READ:
      begin
        bus_rd    = 1'b1;
        bus_addr  = ea;
        bus_cycle = CAL_CYC_R;
      end
      CAL_FREE:
      begin
        bus_cycle = CAL_CYC_F;
      end
      CAL_WRITE:
      begin
        bus_wr    = 1'b1;
        bus_addr  = ea;
        bus_cycle = CAL_CYC_W;
      end
    endcase
  end

  // Alu feeds: shifts work on the fetched operand or A/X
  always_comb
  begin
    aif.op       = kind;
    aif.a        = accum;
    aif.flags_in = condition_flags_reg;
    aif.m        = operand;
    if (kind == CAL_ALU_ASL || kind == CAL_ALU_ASR)
    begin
      if (opcode[7:4] == 4'h4)
        aif.m = accum;
      else if (opcode[7:4] == 4'h5)
        aif.m = xreg;
    end
  end

  logic [7:0] byte_in;
  assign byte_in = (state == CAL_READ) ? bus_rdata : operand;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state               <= CAL_FETCH;
      opcode              <= CAL_BYTE_RST;
      pfx                 <= 1'b0;
      ea                  <= CAL_WORD_RST;
      operand             <= CAL_BYTE_RST;
      rmw_res             <= CAL_BYTE_RST;
      prog_ctr            <= CAL_WORD_RST;
      accum               <= CAL_BYTE_RST;
      xreg                <= CAL_BYTE_RST;
      hreg                <= CAL_BYTE_RST;
      stack_ptr           <= CAL_SP_RST;
      condition_flags_reg <= CAL_FLAGS_RST;
      illegal_op          <= 1'b0;
    end
    else
    begin
      unique case (state)
        CAL_FETCH:
        begin
          prog_ctr <= prog_ctr + 16'h0001;
          pfx      <= 1'b0;
          illegal_op <= 1'b0;
          if (bus_rdata == CAL_OP_PREFIX)
            state <= CAL_PREFIX;
          else
          begin
            opcode <= bus_rdata;
            if (cal_decode(bus_rdata) == CAL_ALU_NONE && bus_rdata != CAL_OP_SP_ADJ
                && bus_rdata != CAL_OP_IX_ADJ)
              illegal_op <= 1'b1;
            else if (bus_rdata[7:4] == 4'h4 || bus_rdata[7:4] == 4'h5)
            begin
              opcode <= bus_rdata;
              state  <= CAL_FREE;
            end
            else if (bus_rdata[7:4] == 4'h7 || bus_rdata[7:4] == 4'hF)
            begin
              ea    <= hx;
              state <= CAL_READ;
            end
            else
              state <= CAL_OPND;
          end
        end
        CAL_PREFIX:
        begin
          prog_ctr <= prog_ctr + 16'h0001;
          opcode   <= bus_rdata;
          pfx      <= 1'b1;
          if (cal_decode(bus_rdata) == CAL_ALU_NONE ||
              !(bus_rdata[7:4] == CAL_HI_SP1 || bus_rdata[7:4] == CAL_HI_SP2 || bus_rdata[7:4] == 4'h6))
          begin
            illegal_op <= 1'b1;
            state      <= CAL_FETCH;
          end
          else
            state <= CAL_OPND;
        end
        CAL_OPND:
        begin
          prog_ctr <= prog_ctr + 16'h0001;
          operand  <= bus_rdata;
          unique case (opcode[7:4])
            4'hA:
            begin
              state <= CAL_FREE;
              ea    <= CAL_WORD_RST;
            end
            4'hB, 4'h3:
            begin
              ea    <= {8'h00, bus_rdata};
              state <= CAL_READ;
            end
            4'hE, 4'h6:
            begin
              ea    <= (pfx ? stack_ptr : hx) + {8'h00, bus_rdata};
              state <= CAL_READ;
            end
            default:
            begin
              ea    <= {bus_rdata, 8'h00};
              state <= CAL_OFS2;
            end
          endcase
        end
        CAL_OFS2:
        begin
          prog_ctr <= prog_ctr + 16'h0001;
          if (opcode[7:4] == 4'hC)
            ea <= {ea[15:8], bus_rdata};
          else
            ea <= (pfx ? stack_ptr : hx) + {ea[15:8], bus_rdata};
          state <= CAL_READ;
        end
        CAL_READ:
        begin
          operand <= bus_rdata;
          state   <= CAL_FREE;
        end
        CAL_FREE:
        begin
          state <= CAL_FETCH;
          if (opcode == CAL_OP_SP_ADJ)
            stack_ptr <= stack_ptr + cal_sext(operand);
          else if (opcode == CAL_OP_IX_ADJ)
            {hreg, xreg} <= hx + cal_sext(operand);
          else
          begin
            condition_flags_reg <= aif.flags_out;
            if (kind == CAL_ALU_ASL || kind == CAL_ALU_ASR)
            begin
              if (opcode[7:4] == 4'h4)
                accum <= aif.result;
              else if (opcode[7:4] == 4'h5)
                xreg <= aif.result;
              else
              begin
                rmw_res <= aif.result;
                state   <= CAL_WRITE;
              end
            end
            else
              accum <= aif.result;
          end
        end
        CAL_WRITE:
        begin
          state <= CAL_FETCH;
        end
      endcase
    end
  end

  logic unused_ok;
  assign unused_ok = inh ^ adj ^ byte_in[0];
endmodule

// ===== dv/cal_core_props.sv
// Checker of bus cycle codes and flag relations of the sequencer.
// Bound onto every cal_core; sees its ports only.
`timescale 1ns/1ps
module cal_core_props
  import cal_pkg::*;
(
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire logic [15:0]        bus_addr,
  input wire logic [7:0]         bus_wdata,
  input wire logic [7:0]         bus_rdata,
  input wire logic               bus_rd,
  input wire logic               bus_wr,
  input wire cal_pkg::cal_cyc_e  bus_cycle,
  input wire logic [7:0]         accum,
  input wire logic [7:0]         xreg,
  input wire logic [7:0]         hreg,
  input wire logic [15:0]        stack_ptr,
  input wire logic [7:0]         condition_flags_reg
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  wire [7:0] f = condition_flags_reg;

  a_write_cycle_code: assert property (bus_wr |-> bus_cycle == CAL_CYC_W && !bus_rd)
    else $error("write outside a w cycle");
  a_free_cycle_idle: assert property (bus_cycle == CAL_CYC_F |-> !bus_rd && !bus_wr)
    else $error("bus used in a free cycle");
  a_read_cycle_strobe: assert property (bus_cycle inside {CAL_CYC_P, CAL_CYC_R} |-> bus_rd && !bus_wr)
    else $error("p or r cycle without read strobe");
  a_rmw_order: assert property (bus_wr |->
    $past(bus_cycle) == CAL_CYC_F && $past(bus_cycle, 2) == CAL_CYC_R && $past(bus_addr, 2) == bus_addr)
    else $error("write not preceded by read and free cycle");
  a_shift_write_data: assert property (bus_wr |->
    (bus_wdata == {$past(bus_rdata[6:0], 2), 1'b0} && f[0] == $past(bus_rdata[7], 2)) ||
    (bus_wdata == $past({bus_rdata[7], bus_rdata[7:1]}, 2) && f[0] == $past(bus_rdata[0], 2)))
    else $error("shifted byte or carry wrong");
  a_shift_write_flags: assert property (bus_wr |->
    f[2] == bus_wdata[7] && f[1] == (bus_wdata == 8'h00) && f[7] == (f[2] ^ f[0]))
    else $error("flags after memory shift wrong");
  a_accum_nz: assert property ($changed(accum) |-> f[2] == accum[7] && f[1] == (accum == 8'h00))
    else $error("N or Z disagree with accumulator");
  a_sp_adjust_range: assert property ($changed(stack_ptr) |->
    16'(stack_ptr - $past(stack_ptr) + 16'h0080) < 16'h0100 && $stable(f))
    else $error("stack pointer step out of range or flags moved");
  a_index_adjust_range: assert property ($changed(hreg) |->
    16'({hreg, xreg} - $past({hreg, xreg}) + 16'h0080) < 16'h0100 && $stable(f))
    else $error("index pair step out of range or flags moved");
endmodule

bind cal_core cal_core_props cal_core_props_i (.sys_clk, .sys_rst, .bus_addr, .bus_wdata, .bus_rdata, .bus_rd,
  .bus_wr, .bus_cycle, .accum, .xreg, .hreg, .stack_ptr, .condition_flags_reg);

// ===== dv/cal_mem_model.sv
// Byte memory answering the sequencer's bus in the same cycle.
// Assumes the bench preloads mem before reset is released.
`timescale 1ns/1ps
module cal_mem_model
(
  input  wire logic        sys_clk,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;
  // read answered in its own cycle
  // Idle bus shows inverted data so stale bytes never match
  assign bus_rdata = bus_rd ? mem[bus_addr] : ~last;
  always @(posedge sys_clk)
  begin
    if (bus_rd)
      last <= bus_rdata;
    if (bus_wr)
      mem[bus_addr] <= bus_wdata;
  end
endmodule

// ===== dv/testbench.sv
// Self-checking bench: random program checked against a reference model.
// Assumes cal_core and the memory model share one clock.
`timescale 1ns/1ps
module testbench;
  import cal_pkg::*;
  // Second index step wraps the pair so the high byte moves
  localparam logic [7:0] CORNER [18] = '{8'hAB, 8'h80, 8'hAB, 8'h80, 8'hA9, 8'h0F, 8'hAB, 8'h70,
    8'h00, 8'hA4, 8'h00, 8'hA7, 8'h80, 8'hAF, 8'h7F, 8'hAF, 8'h80, 8'h47};
  localparam logic [7:0] FORMS [15] = '{8'hA9, 8'hAB, 8'hA4, 8'hA7, 8'hAF, 8'h38, 8'h48, 8'h58,
    8'h37, 8'h47, 8'h57, 8'hEB, 8'hE4, 8'hE9, 8'hDB};
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] bus_addr, stack_ptr, prog_ctr, rsp, pc, p;
  logic [15:0] ea = 16'h0000;
  logic [7:0]  bus_wdata, bus_rdata, accum, xreg, hreg, flags, ra, rx, rh, rf;
  logic        bus_rd, bus_wr, illegal_op;
  cal_cyc_e    bus_cycle;
  logic [7:0]  sh [0:65535];
  logic [31:0] seed = 32'he132_e018;
  int          fail_count = 0;
  int          check_count = 0;
  int          ill_count = 0;
  int          n;

  always #10 sys_clk = ~sys_clk;
  cal_core cal_core_i (.sys_clk, .sys_rst, .bus_addr, .bus_wdata, .bus_rdata, .bus_rd, .bus_wr, .bus_cycle,
    .accum, .xreg, .hreg, .stack_ptr, .prog_ctr, .condition_flags_reg(flags), .illegal_op);
  cal_mem_model cal_mem_model_i (.sys_clk, .bus_addr, .bus_wdata, .bus_rdata, .bus_rd, .bus_wr);
  always @(posedge sys_clk)
    if (illegal_op === 1'b1)
      ill_count++;

  function automatic logic [7:0] rnd();
    seed = seed[0] ? (seed >> 1) ^ 32'h8020_0003 : seed >> 1;
    return seed[7:0];
  endfunction

  function automatic logic [15:0] ref_alu(cal_alu_e k, logic [7:0] a, logic [7:0] m, logic [7:0] f);
    logic [8:0] s;
    logic [4:0] lo;
    logic [7:0] r, nf;
    logic       ci;
    nf = f;
    ci = k == CAL_ALU_ADC && f[0];
    s = a + m + ci;
    lo = a[3:0] + m[3:0] + ci;
    r = k == CAL_ALU_AND ? a & m : k == CAL_ALU_ASL ? {m[6:0], 1'b0} : k == CAL_ALU_ASR ? {m[7], m[7:1]} : s[7:0];
    case (k)
      CAL_ALU_AND: nf[7] = 1'b0;
      CAL_ALU_ASL: {nf[7], nf[0]} = {r[7] ^ m[7], m[7]};
      CAL_ALU_ASR: {nf[7], nf[0]} = {r[7] ^ m[0], m[0]};
      default: {nf[7], nf[4], nf[0]} = {a[7] == m[7] && r[7] != a[7], lo[4], s[8]};
    endcase
    {nf[2], nf[1]} = {r[7], r == 8'h00};
    return {nf, r};
  endfunction

  task automatic ref_step();
    logic [7:0]  op, o2, m;
    logic [15:0] q;
    cal_alu_e    k;
    op = sh[pc];
    o2 = sh[pc + 16'h0001];
    k = CAL_ALU_NONE;
    // Stack forms: prefix, base byte, then offset high byte first
    if (op == CAL_OP_PREFIX)
    begin
      ea = rsp + (o2[4] ? {sh[pc + 16'h0002], sh[pc + 16'h0003]} : {8'h00, sh[pc + 16'h0002]});
      m = sh[ea];
      pc = pc + (o2[4] ? 16'h0004 : 16'h0003);
      op = {4'hA, o2[3:0]};
    end
    else if (op[7:4] inside {4'hA, 4'h3})
    begin
      ea = op[4] ? {8'h00, o2} : ea;
      m = op[4] ? sh[ea] : o2;
      pc = pc + 16'h0002;
    end
    else
    begin
      m = op[4] ? rx : ra;
      pc = pc + 16'h0001;
    end
    case (op)
      CAL_OP_ADC_IMM: k = CAL_ALU_ADC;
      CAL_OP_ADD_IMM: k = CAL_ALU_ADD;
      CAL_OP_AND_IMM: k = CAL_ALU_AND;
      CAL_OP_SP_ADJ: rsp = rsp + {{8{m[7]}}, m};
      CAL_OP_IX_ADJ: {rh, rx} = {rh, rx} + {{8{m[7]}}, m};
      8'h00: k = CAL_ALU_NONE;
      default: k = op[3] ? CAL_ALU_ASL : CAL_ALU_ASR;
    endcase
    q = ref_alu(k, ra, m, rf);
    if (k != CAL_ALU_NONE)
      rf = q[15:8];
    if (k == CAL_ALU_NONE)
      ;
    else if (op[7:4] == 4'h5)
      rx = q[7:0];
    else if (op[7:4] == 4'h3)
      sh[ea] = q[7:0];
    else
      ra = q[7:0];
  endtask

  task automatic put(logic [7:0] b);
    sh[p] = b;
    p = p + 16'h0001;
  endtask

  task automatic put_form(logic [7:0] o);
    if (o[7:4] >= 4'hD)
    begin
      put(CAL_OP_PREFIX);
      put(o);
      if (o[7:4] == 4'hD)
        put(8'h00);
      put(rnd());
    end
    else
    begin
      put(o);
      if (o[7:4] == 4'hA)
        put(rnd());
      if (o[7:4] == 4'h3)
        put(8'hC0 | (rnd() & 8'h3F));
    end
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    for (n = 0; n < 65536; n++)
      sh[n] = rnd();
    p = 16'h0000;
    foreach (CORNER[i])
      put(CORNER[i]);
    foreach (FORMS[i])
      put_form(FORMS[i]);
    repeat (36)
      put_form(FORMS[rnd() % 15]);
    for (n = 0; n < 65536; n++)
      cal_mem_model_i.mem[n] = sh[n];
    {ra, rx, rh, rf, rsp, pc} = {CAL_BYTE_RST, CAL_BYTE_RST, CAL_BYTE_RST, CAL_FLAGS_RST, CAL_SP_RST, 16'h0000};
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (n = 0; n < 61; n++)
    begin
      ref_step();
      // Bounded wait for the next opcode fetch
      for (int t = 0; t < 20 && !(bus_rd === 1'b1 && bus_cycle === CAL_CYC_P && bus_addr === pc); t++)
        @(negedge sys_clk);
      chk("fetch", pc, bus_addr);
      chk("pc", pc, prog_ctr);
      chk("accum", 16'(ra), 16'(accum));
      chk("flags", 16'(rf), 16'(flags));
      chk("sp", rsp, stack_ptr);
      chk("index", {rh, rx}, {hreg, xreg});
      chk("mem", 16'(sh[ea]), 16'(cal_mem_model_i.mem[ea]));
    end
    chk("illegal", 16'h0001, 16'(ill_count));
    end_of_test();
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end
endmodule
